//--- common/slcd_pkg.sv
// constants, types and carriers of the segment lcd display ram and backplane mux core
package slcd_pkg;
  localparam int NUM_COLUMNS = 80;
  localparam int NUM_ROWS = 4;
  localparam int PTR_W = 7;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 24;
  localparam logic [PTR_W-1:0] LAST_COLUMN = 7'h4F;
  localparam logic [PTR_W-1:0] PTR_RESET = 7'h00;
  // clock rates and frame rates in hertz, then the frame lengths they give in core and link cycles
  localparam int CLOCK_HZ = 50_000_000;
  localparam int LINK_HZ = 12_500_000;
  localparam int FRAME_HZ_SLOW = 82;
  localparam int FRAME_HZ_FAST = 110;
  localparam int FRAME_CYCLES_SLOW = CLOCK_HZ / FRAME_HZ_SLOW;
  localparam int FRAME_CYCLES_FAST = CLOCK_HZ / FRAME_HZ_FAST;
  localparam int LINK_FRAME_SLOW = LINK_HZ / FRAME_HZ_SLOW;
  localparam int LINK_FRAME_FAST = LINK_HZ / FRAME_HZ_FAST;
  // half period of the clock driven out for cascaded devices, in core cycles
  localparam logic [3:0] CLK_OUT_HALF = 4'h4;
  // pointer steps per drive mode
  localparam logic [PTR_W-1:0] STEP_STATIC = 7'h08;
  localparam logic [PTR_W-1:0] STEP_MUX2 = 7'h04;
  localparam logic [PTR_W-1:0] STEP_MUX3 = 7'h03;
  localparam logic [PTR_W-1:0] STEP_MUX4 = 7'h02;

  typedef enum logic [1:0] {
    MODE_STATIC = 2'b00,
    MODE_MUX2 = 2'b01,
    MODE_MUX3 = 2'b10,
    MODE_MUX4 = 2'b11
  } slcd_mode_e;

  localparam slcd_mode_e MODE_RESET = MODE_MUX4;

  typedef struct packed {
    logic valid;
    logic [BYTE_W-1:0] data;
  } slcd_write_s;

  typedef struct packed {
    logic load;
    logic [PTR_W-1:0] value;
  } slcd_ptr_s;

  typedef struct packed {
    logic set;
    slcd_mode_e mode;
  } slcd_mode_cmd_s;
endpackage

//--- verilog/slcd_core.sv
// segment lcd core: display ram, data pointer, phase timing, segment and backplane drive
module slcd_core import slcd_pkg::*; #(
  parameter int FRAME_SLOW = FRAME_CYCLES_SLOW,
  parameter int FRAME_FAST = FRAME_CYCLES_FAST,
  parameter int LINK_SLOW = LINK_FRAME_SLOW,
  parameter int LINK_FAST = LINK_FRAME_FAST
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_link_clock,
  input wire logic i_oscillator_source_select_pin,
  input wire logic i_frame_rate_select_pin,
  input wire logic i_display_enable,
  input wire slcd_write_s i_write,
  input wire slcd_ptr_s i_ptr,
  input wire slcd_mode_cmd_s i_mode_cmd,
  output logic [NUM_COLUMNS-1:0] o_segment_outputs,
  output logic [NUM_ROWS-1:0] o_backplane_outputs,
  output logic o_clk_pin,
  output logic o_clk_pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  // column sum modulo 80 by one subtraction of 80, so the sum must stay below 160
  function automatic logic [PTR_W-1:0] col_add(input logic [PTR_W-1:0] a,
                                               input logic [PTR_W-1:0] b);
    logic [PTR_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s > {1'b0, LAST_COLUMN}) begin
      s = s - 8'h50;
    end
    return s[PTR_W-1:0];
  endfunction

  function automatic logic [PTR_W-1:0] ptr_step(input slcd_mode_e m);
    unique case (m)
      MODE_STATIC: ptr_step = STEP_STATIC;
      MODE_MUX2: ptr_step = STEP_MUX2;
      MODE_MUX3: ptr_step = STEP_MUX3;
      MODE_MUX4: ptr_step = STEP_MUX4;
    endcase
  endfunction

  // number of multiplexed rows minus one
  function automatic logic [1:0] last_row(input slcd_mode_e m);
    return m;
  endfunction

  // cycles per phase: a frame holds two polarity halves of n phases each
  function automatic logic [CNT_W-1:0] phase_len(input int frame, input slcd_mode_e m);
    int n;
    n = int'(m) + 1;
    return CNT_W'(frame / (2 * n));
  endfunction

  // which ram row a backplane pin follows in each drive mode
  function automatic logic [1:0] bp_row(input slcd_mode_e m, input int pin);
    logic [1:0] p;
    p = 2'(pin);
    unique case (m)
      MODE_STATIC: bp_row = 2'h0;
      MODE_MUX2: bp_row = {1'b0, p[0]};
      MODE_MUX3: bp_row = (p == 2'h3) ? 2'h1 : p;
      MODE_MUX4: bp_row = p;
    endcase
  endfunction

  // new content of one ram word; off is the column distance from the write base
  function automatic logic [NUM_ROWS-1:0] fill_word(input logic [NUM_ROWS-1:0] old,
                                                   input logic [PTR_W-1:0] off,
                                                   input slcd_mode_e m,
                                                   input logic [BYTE_W-1:0] b);
    logic [NUM_ROWS-1:0] w;
    int n;
    int pos;
    w = old;
    n = int'(m) + 1;
    for (int r = 0; r < NUM_ROWS; r++) begin
      pos = int'(off) * n + r;
      if (r < n && pos < BYTE_W) begin
        w[r] = b[BYTE_W-1-pos]; // msb goes to the lowest row of the first column
      end
    end
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers into the core domain

  logic osc_meta;
  logic osc_sel;
  logic ff_meta;
  logic ff_sel;

  always_ff @(posedge i_clock) begin
    osc_meta <= i_oscillator_source_select_pin;
    osc_sel <= osc_meta;
    ff_meta <= i_frame_rate_select_pin;
    ff_sel <= ff_meta;
  end

  ////////////////////////////////////////////////////////////////////////////
  // drive mode and display enable

  slcd_mode_e drive_mode;
  logic display_on;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      drive_mode <= MODE_RESET;
      display_on <= 1'b0;
    end else begin
      if (i_mode_cmd.set) begin
        drive_mode <= i_mode_cmd.mode;
      end
      display_on <= i_display_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // display ram and data pointer

  logic [NUM_ROWS-1:0] ram [NUM_COLUMNS];
  logic [PTR_W-1:0] data_ptr;
  wire [PTR_W-1:0] load_value = col_add(i_ptr.value, 7'h00);
  // a load in the same cycle as a byte places that byte at the loaded address
  wire [PTR_W-1:0] write_base = i_ptr.load ? load_value : data_ptr;
  wire [PTR_W-1:0] next_ptr = col_add(write_base, ptr_step(drive_mode));

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      data_ptr <= PTR_RESET;
    end else if (i_write.valid) begin
      data_ptr <= next_ptr;
    end else if (i_ptr.load) begin
      data_ptr <= load_value;
    end
  end

  // byte lands in the very cycle it is offered, no acknowledge wait
  always_ff @(posedge i_clock) begin
    for (int c = 0; c < NUM_COLUMNS; c++) begin
      if (i_rst) begin
        ram[c] <= '0;
      end else if (i_write.valid) begin
        ram[c] <= fill_word(ram[c], col_add(PTR_W'(c), 7'h50 - write_base), drive_mode,
                            i_write.data);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link domain: phase toggles counted on the external clock

  logic link_rst_meta;
  logic link_rst;
  logic [2:0] link_cfg_meta;
  logic [2:0] link_cfg;
  logic [2:0] link_cfg_prev;
  logic [2:0] link_cfg_ok;
  logic [CNT_W-1:0] link_cnt;
  logic link_tog;
  // the word is taken only after two equal samples, so bits caught mid-change never mix
  wire slcd_mode_e link_mode = slcd_mode_e'(link_cfg_ok[1:0]);
  wire [CNT_W-1:0] link_len = phase_len(link_cfg_ok[2] ? LINK_SLOW : LINK_FAST, link_mode);

  always_ff @(posedge i_link_clock) begin
    link_rst_meta <= i_rst;
    link_rst <= link_rst_meta;
    link_cfg_meta <= {ff_sel, drive_mode};
    link_cfg <= link_cfg_meta;
    link_cfg_prev <= link_cfg;
    if (link_cfg == link_cfg_prev) begin
      link_cfg_ok <= link_cfg;
    end
  end

  always_ff @(posedge i_link_clock) begin
    if (link_rst) begin
      link_cnt <= '0;
      link_tog <= 1'b0;
    end else if (link_cnt >= link_len - 24'h1) begin
      link_cnt <= '0;
      link_tog <= ~link_tog;
    end else begin
      link_cnt <= link_cnt + 24'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // phase tick selection; a stopped external clock simply stops all phases

  logic ext_meta;
  logic ext_sync;
  logic ext_prev;
  logic [CNT_W-1:0] int_cnt;
  wire [CNT_W-1:0] int_len = phase_len(ff_sel ? FRAME_SLOW : FRAME_FAST, drive_mode);
  wire int_tick = (int_cnt >= int_len - 24'h1);
  wire ext_tick = ext_sync ^ ext_prev;
  wire phase_tick = osc_sel ? ext_tick : int_tick;

  always_ff @(posedge i_clock) begin
    ext_meta <= link_tog;
    ext_sync <= ext_meta;
    ext_prev <= ext_sync;
  end

  always_ff @(posedge i_clock) begin
    // a mode set restarts the phase count so the new phase zero is full length
    if (i_rst || osc_sel || int_tick || i_mode_cmd.set) begin
      int_cnt <= '0;
    end else begin
      int_cnt <= int_cnt + 24'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock pin: internal clock driven out only when the internal source is chosen

  logic [3:0] clk_div;
  wire next_clk_pin_oe = ~osc_sel;
  wire clk_div_wrap = (clk_div >= CLK_OUT_HALF - 4'h1);
  // forced low at once in external mode, not left high until the next wrap
  wire next_clk_pin = (clk_div_wrap ? ~o_clk_pin : o_clk_pin) & next_clk_pin_oe;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      clk_div <= 4'h0;
      o_clk_pin <= 1'b0;
      o_clk_pin_oe <= 1'b0;
    end else begin
      o_clk_pin_oe <= next_clk_pin_oe;
      o_clk_pin <= next_clk_pin;
      if (clk_div_wrap) begin
        clk_div <= 4'h0;
      end else begin
        clk_div <= clk_div + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // phase sequencer and display register

  logic [1:0] row_sel;
  logic polarity;
  logic [NUM_COLUMNS-1:0] disp_reg;
  wire [1:0] next_row = (row_sel >= last_row(drive_mode)) ? 2'h0 : row_sel + 2'h1;

  always_ff @(posedge i_clock) begin
    if (i_rst || i_mode_cmd.set) begin
      row_sel <= 2'h0;
      polarity <= 1'b0;
    end else if (phase_tick) begin
      row_sel <= next_row;
      polarity <= (next_row == 2'h0) ? ~polarity : polarity; // inversion keeps dc off
    end
  end

  // the register holds a whole row, so ram writes show only at the next phase
  always_ff @(posedge i_clock) begin
    for (int c = 0; c < NUM_COLUMNS; c++) begin
      if (i_rst) begin
        disp_reg[c] <= 1'b0;
      end else if (i_mode_cmd.set) begin
        disp_reg[c] <= ram[c][0]; // restarted phase zero shows row 0
      end else if (phase_tick) begin
        disp_reg[c] <= ram[c][next_row];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output drive: selected backplane opposes polarity, on segments follow it

  wire [NUM_COLUMNS-1:0] next_segment = display_on ? ~(disp_reg ^ {NUM_COLUMNS{polarity}})
                                                   : '0;
  logic [NUM_ROWS-1:0] next_backplane;

  always_comb begin
    for (int i = 0; i < NUM_ROWS; i++) begin
      next_backplane[i] = display_on &
                          ((bp_row(drive_mode, i) == row_sel) ^ polarity);
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_segment_outputs <= '0;
      o_backplane_outputs <= '0;
    end else begin
      o_segment_outputs <= next_segment;
      o_backplane_outputs <= next_backplane;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks and the helper state they use

  logic [PTR_W-1:0] wr_base_q;
  logic [BYTE_W-1:0] wr_byte_q;
  logic wr_row3_q;
  slcd_mode_e wr_mode_q;

  always_ff @(posedge i_clock) begin
    wr_base_q <= write_base;
    wr_byte_q <= i_write.data;
    wr_row3_q <= ram[col_add(write_base, 7'h02)][3];
    wr_mode_q <= drive_mode;
  end

  a_clk_pin_driven: assert property (@(posedge i_clock) disable iff (i_rst)
    !osc_sel |=> o_clk_pin_oe) else $error("clock pin not driven with internal source");
  a_clk_pin_input: assert property (@(posedge i_clock) disable iff (i_rst)
    osc_sel |=> !o_clk_pin_oe && !o_clk_pin) else $error("clock pin driven in external mode");
  a_reset_state: assert property (@(posedge i_clock)
    i_rst |=> drive_mode == MODE_MUX4 && o_segment_outputs == '0 && o_backplane_outputs == '0)
    else $error("reset state wrong");
  a_mux3_pins: assert property (@(posedge i_clock) disable iff (i_rst)
    ($past(drive_mode) == MODE_MUX3) |-> o_backplane_outputs[3] == o_backplane_outputs[1])
    else $error("backplane three differs from one");
  a_mux2_pins: assert property (@(posedge i_clock) disable iff (i_rst)
    ($past(drive_mode) == MODE_MUX2) |-> o_backplane_outputs[2:0] == {o_backplane_outputs[0],
    o_backplane_outputs[3], o_backplane_outputs[2]}) else $error("duplex pin pairs differ");
  a_static_pins: assert property (@(posedge i_clock) disable iff (i_rst)
    ($past(drive_mode) == MODE_STATIC) |-> (o_backplane_outputs == 4'h0 ||
    o_backplane_outputs == 4'hF)) else $error("static backplanes differ");
  a_disp_reg_hold: assert property (@(posedge i_clock) disable iff (i_rst)
    !phase_tick && !i_mode_cmd.set |=> $stable(disp_reg))
    else $error("display register changed mid phase");
  a_static_fill: assert property (@(posedge i_clock) disable iff (i_rst)
    i_write.valid && drive_mode == MODE_STATIC |=> ram[wr_base_q][0] == wr_byte_q[7] &&
    ram[col_add(wr_base_q, 7'h07)][0] == wr_byte_q[0]) else $error("static fill wrong");
  a_mux2_fill: assert property (@(posedge i_clock) disable iff (i_rst)
    i_write.valid && drive_mode == MODE_MUX2 |=> ram[wr_base_q][1] == wr_byte_q[6] &&
    ram[col_add(wr_base_q, 7'h03)][1] == wr_byte_q[0]) else $error("duplex fill wrong");
  a_mux3_row3_kept: assert property (@(posedge i_clock) disable iff (i_rst)
    i_write.valid && drive_mode == MODE_MUX3 |=> ram[col_add(wr_base_q, 7'h02)][3] == wr_row3_q
    && ram[col_add(wr_base_q, 7'h02)][1] == wr_byte_q[0]) else $error("triplet fill wrong");
  a_mux4_fill: assert property (@(posedge i_clock) disable iff (i_rst)
    i_write.valid && drive_mode == MODE_MUX4 |=> ram[wr_base_q] == {wr_byte_q[4],
    wr_byte_q[5], wr_byte_q[6], wr_byte_q[7]}) else $error("nibble fill wrong");
  a_ptr_step: assert property (@(posedge i_clock) disable iff (i_rst)
    i_write.valid |=> data_ptr == col_add(wr_base_q, ptr_step(wr_mode_q)))
    else $error("pointer step wrong");
  a_ptr_load: assert property (@(posedge i_clock) disable iff (i_rst)
    i_ptr.load && !i_write.valid |=> data_ptr == $past(load_value))
    else $error("pointer load lost");
  a_ptr_range: assert property (@(posedge i_clock) disable iff (i_rst)
    data_ptr <= LAST_COLUMN) else $error("pointer beyond last column");
  a_phase_period: assert property (@(posedge i_clock) disable iff (i_rst)
    !osc_sel && int_cnt == 24'h0 |-> int_len > 24'h0) else $error("zero phase length");

endmodule

//--- bench/slcd_host_model.sv
// host-side partner: display byte stream, pointer and mode commands, free-running link clock
module slcd_host_model import slcd_pkg::*; (
  input wire logic i_clock,
  output logic o_link_clock,
  output slcd_write_s o_write,
  output slcd_ptr_s o_ptr,
  output slcd_mode_cmd_s o_mode_cmd,
  output logic o_display_enable
);
  timeunit 1ns;
  timeprecision 100ps;

  ////////////////////////////////////////////////////////////////////////////////
  // idle values at time zero; the link clock never stops, a halted one could leave dc
  // the host leaves its bus idle from power-up so an internal clock can start
  initial begin
    o_write = '0;
    o_ptr = '0;
    o_mode_cmd = '0;
    o_display_enable = 1'b0;
    o_link_clock = 1'b0;
    #13;
    forever #40 o_link_clock = ~o_link_clock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // command tasks: mode and pointer strobes are one-cycle pulses launched just after an edge
  task automatic set_mode(input slcd_mode_e m);
    @(posedge i_clock);
    o_mode_cmd <= '{set: 1'b1, mode: m};
    @(posedge i_clock);
    o_mode_cmd <= '0;
  endtask

  // every ram access starts from a freshly loaded pointer, never a stale one
  task automatic load_ptr(input logic [PTR_W-1:0] v);
    @(posedge i_clock);
    o_ptr <= '{load: 1'b1, value: v};
    @(posedge i_clock);
    o_ptr <= '0;
  endtask

  // bytes go back to back, one per cycle, valid held high across the burst
  task automatic send_bytes(input logic [BYTE_W-1:0] q[$]);
    foreach (q[i]) begin
      @(posedge i_clock);
      o_write <= '{valid: 1'b1, data: q[i]};
    end
    @(posedge i_clock);
    o_write <= '0;
  endtask

  task automatic set_display(input logic on);
    @(posedge i_clock);
    o_display_enable <= on;
  endtask
endmodule

//--- bench/slcd_tb.sv
// self-checking bench of the segment lcd core: ram fill, pointer steps, backplane patterns, clocks
module tb import slcd_pkg::*; ();
  timeunit 1ns;
  timeprecision 100ps;
  // short frames keep the run small; link frame of 24 cycles at 80 ns equals 96 core cycles
  localparam int F_SLOW = 144;
  localparam int F_FAST = 96;
  localparam int L_SLOW = 48;
  localparam int L_FAST = 24;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic osc_pin = 1'b0;
  logic rate_pin = 1'b0;
  logic link_clock;
  logic display_enable;
  slcd_write_s wr;
  slcd_ptr_s ptr;
  slcd_mode_cmd_s mode_cmd;
  logic [NUM_COLUMNS-1:0] seg;
  logic [NUM_ROWS-1:0] bp;
  logic clk_pin;
  logic clk_oe;
  int num_errors = 0;
  int total_checks = 0;
  logic [NUM_ROWS-1:0] exp_ram [NUM_COLUMNS] = '{default: '0};
  int exp_ptr = 0;

  // core clock, 50 MHz
  always #10 i_clock = ~i_clock;

  slcd_host_model host (.i_clock(i_clock), .o_link_clock(link_clock), .o_write(wr), .o_ptr(ptr),
    .o_mode_cmd(mode_cmd), .o_display_enable(display_enable));

  slcd_core #(.FRAME_SLOW(F_SLOW), .FRAME_FAST(F_FAST), .LINK_SLOW(L_SLOW), .LINK_FAST(L_FAST)) DUT (
    .i_clock(i_clock), .i_rst(i_rst), .i_link_clock(link_clock),
    .i_oscillator_source_select_pin(osc_pin), .i_frame_rate_select_pin(rate_pin),
    .i_display_enable(display_enable), .i_write(wr), .i_ptr(ptr), .i_mode_cmd(mode_cmd),
    .o_segment_outputs(seg), .o_backplane_outputs(bp), .o_clk_pin(clk_pin), .o_clk_pin_oe(clk_oe));

  ////////////////////////////////////////////////////////////////////////////////
  // verdict and compare helpers
  task automatic wrap_up();
    if (num_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check_vec(input logic [NUM_COLUMNS-1:0] got, input logic [NUM_COLUMNS-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_nib(input logic [3:0] got, input logic [3:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // counts measured on the outputs; tol absorbs synchroniser jitter
  task automatic check_num(input int got, input int exp, input int tol);
    total_checks++;
    if (got < exp - tol || got > exp + tol) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // reference model of the ram, pointer and backplane selection
  function automatic int rows_of(input slcd_mode_e m);
    return int'(m) + 1;
  endfunction

  // pins that follow row r while its polarity is positive
  function automatic logic [3:0] sel_pat(input slcd_mode_e m, input int r);
    logic [3:0] p;
    int rop;
    for (int i = 0; i < 4; i++) begin
      rop = (m == MODE_STATIC) ? 0 : (m == MODE_MUX2) ? i % 2 : (m == MODE_MUX3 && i == 3) ? 1 : i;
      p[i] = (rop == r);
    end
    return p;
  endfunction

  // msb first, rows fastest, columns wrap; step is the number of words touched
  task automatic model_byte(input slcd_mode_e m, input logic [BYTE_W-1:0] d);
    int n;
    n = rows_of(m);
    for (int k = 0; k < 8; k++) begin
      exp_ram[(exp_ptr + k / n) % NUM_COLUMNS][k % n] = d[7-k];
    end
    exp_ptr = (exp_ptr + (8 + n - 1) / n) % NUM_COLUMNS;
  endtask

  task automatic fill(input slcd_mode_e m, input logic [PTR_W-1:0] v, input logic [BYTE_W-1:0] q[$]);
    host.load_ptr(v);
    exp_ptr = int'(v) % NUM_COLUMNS;
    foreach (q[i]) model_byte(m, q[i]);
    host.send_bytes(q);
  endtask

  // a mode set restarts the sequence; each row is read in the middle of its inverted phase
  task automatic read_rows(input slcd_mode_e m);
    int n;
    int p;
    logic [NUM_COLUMNS-1:0] e;
    n = rows_of(m);
    p = F_FAST / (2 * n);
    for (int r = 0; r < n; r++) begin
      host.set_mode(m);
      repeat ((n + r) * p + p / 2) @(posedge i_clock);
      @(negedge i_clock);
      for (int c = 0; c < NUM_COLUMNS; c++) e[c] = exp_ram[c][r];
      check_nib(bp, ~sel_pat(m, r));
      check_vec(seg, e);
    end
  endtask

  // waits, bounded, until the watched output equals v (eq=1) or differs from it (eq=0)
  task automatic wait_on(input bit pin, input logic [3:0] v, input bit eq, inout int cnt);
    int n;
    for (n = 0; n < 3000; n++) begin
      @(negedge i_clock);
      cnt++;
      if (((pin ? {3'h0, clk_pin} : bp) === v) == eq) break;
    end
    if (n == 3000) begin
      num_errors++;
      wrap_up();
    end
  endtask

  // cycles between two entries into pattern v; the first period is discarded
  task automatic period(input bit pin, input logic [3:0] v, output int cnt);
    cnt = 0;
    wait_on(pin, v, 0, cnt);
    wait_on(pin, v, 1, cnt);
    cnt = 0;
    wait_on(pin, v, 0, cnt);
    wait_on(pin, v, 1, cnt);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic s_reset();
    int cnt;
    repeat (3) @(negedge i_clock);
    check_vec(seg, '0);
    check_nib(bp, 4'h0);
    check_nib({3'h0, clk_oe}, 4'h0);
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    @(negedge i_clock);
    check_nib(bp, 4'h0);
    host.set_display(1'b1);
    cnt = 0;
    wait_on(1'b0, 4'h0, 1'b0, cnt);
    host.set_display(1'b0);
    repeat (3) @(negedge i_clock);
    check_vec(seg, '0);
    check_nib(bp, 4'h0);
  endtask

  task automatic s_clock_internal();
    int cnt;
    period(1'b1, 4'h1, cnt);
    check_num(cnt, 2 * int'(CLK_OUT_HALF), 0);
    check_nib({3'h0, clk_oe}, 4'h1);
  endtask

  task automatic s_rate();
    int cnt;
    host.set_display(1'b1);
    host.set_mode(MODE_MUX4);
    rate_pin <= 1'b1;
    period(1'b0, 4'h1, cnt);
    period(1'b0, 4'h1, cnt);
    check_num(cnt, F_SLOW, 1);
    rate_pin <= 1'b0;
    period(1'b0, 4'h1, cnt);
    period(1'b0, 4'h1, cnt);
    check_num(cnt, F_FAST, 1);
  endtask

  // mode set to mux4 in s_rate: it must give the four-row fill and step of two
  task automatic s_mux4();
    fill(MODE_MUX4, 7'h4E, '{8'h96, 8'hE1, 8'hF0});
    fill(MODE_MUX4, 7'h0A, '{8'hFF, 8'hFF, 8'hFF});
    read_rows(MODE_MUX4);
  endtask

  // row 3 of the words written here was set beforehand and must survive
  task automatic s_mux3();
    host.set_mode(MODE_MUX3);
    fill(MODE_MUX3, 7'h0A, '{8'h5A, 8'hC3});
    read_rows(MODE_MUX3);
    read_rows(MODE_MUX4);
  endtask

  task automatic s_static();
    host.set_mode(MODE_STATIC);
    fill(MODE_STATIC, 7'h55, '{8'h81});
    fill(MODE_STATIC, 7'h4C, '{8'h42, 8'h18});
    read_rows(MODE_STATIC);
  endtask

  task automatic s_mux2();
    host.set_mode(MODE_MUX2);
    fill(MODE_MUX2, 7'h28, '{8'h6B, 8'h9D});
    read_rows(MODE_MUX2);
  endtask

  // long reset so the link domain sees several of its own edges
  task automatic s_external();
    int cnt;
    @(posedge i_clock);
    i_rst <= 1'b1;
    osc_pin <= 1'b1;
    repeat (16) @(posedge i_clock);
    i_rst <= 1'b0;
    host.set_mode(MODE_MUX4);
    period(1'b0, 4'h1, cnt);
    period(1'b0, 4'h1, cnt);
    check_num(cnt, L_FAST * 4, 3);
    check_nib({3'h0, clk_oe}, 4'h0);
    check_nib({3'h0, clk_pin}, 4'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    s_reset();
    s_clock_internal();
    s_rate();
    s_mux4();
    s_mux3();
    s_static();
    s_mux2();
    s_external();
    wrap_up();
  end
endmodule
